// *** core/css_map.svh ***
// Timing counts and level codes for the startup protection sequencer
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
`define CSS_CLK_HZ        10000000
`define CSS_SS1_US        500
`define CSS_SS2_US        1000
`define CSS_SS3_US        2000
`define CSS_SS4_US        4000
`define CSS_OLP_MS        64
`define CSS_SS1_CYC       ((`CSS_CLK_HZ / 1000000) * `CSS_SS1_US)
`define CSS_SS2_CYC       ((`CSS_CLK_HZ / 1000000) * `CSS_SS2_US)
`define CSS_SS3_CYC       ((`CSS_CLK_HZ / 1000000) * `CSS_SS3_US)
`define CSS_SS4_CYC       ((`CSS_CLK_HZ / 1000000) * `CSS_SS4_US)
`define CSS_OLP_CYC       ((`CSS_CLK_HZ / 1000) * `CSS_OLP_MS)
`define CSS_LIM_010       3'h0
`define CSS_LIM_015       3'h1
`define CSS_LIM_020       3'h2
`define CSS_LIM_030       3'h3
`define CSS_LIM_FULL      3'h4
`endif

// *** core/css_pkg.sv ***
// Types shared by the startup protection sequencer
package css_pkg;
    typedef enum logic [2:0] {
        CSS_ST_SHORT,
        CSS_ST_CHARGE,
        CSS_ST_RUN,
        CSS_ST_OLP_WAIT,
        CSS_ST_RECHARGE
    } css_state_t;
    typedef logic [2:0] css_lim_t;
endpackage

// *** core/css_sync_if.sv ***
// Bundle of synchronised comparator flags
`timescale 1ns/10ps
interface css_sync_if;
    logic short_ok;
    logic uv_release;
    logic uv_trip;
    logic prot_ok;
    logic olp_rise;
    logic olp_fall;
    logic light_load;
    modport src (output short_ok, uv_release, uv_trip, prot_ok,
                 output olp_rise, olp_fall, light_load);
    modport dst (input short_ok, uv_release, uv_trip, prot_ok,
                 input olp_rise, olp_fall, light_load);
endinterface

// *** core/css_sync.sv ***
// Three-stage synchroniser bank for the comparator flags
`timescale 1ns/10ps
module css_sync #(
    parameter int N = 7
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic [N-1:0] async_i,
    output logic      [N-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            logic s1_ff, s2_ff, s3_ff, out_ff;
            // First stage feeds only the second; change taken once 2 and 3 agree
            always_ff @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_ff  <= 1'b0;
                    s2_ff  <= 1'b0;
                    s3_ff  <= 1'b0;
                    out_ff <= 1'b0;
                end else begin
                    s1_ff <= async_i[g];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff) begin
                        out_ff <= s3_ff;
                    end
                end
            end
            assign sync_o[g] = out_ff;
        end
    endgenerate
endmodule

// *** core/css_softstart.sv ***
// Soft-start timer stepping the per-cycle current limit code
`timescale 1ns/10ps
`include "css_map.svh"
module css_softstart #(
    parameter int SS1_CYC = `CSS_SS1_CYC,
    parameter int SS2_CYC = `CSS_SS2_CYC,
    parameter int SS3_CYC = `CSS_SS3_CYC,
    parameter int SS4_CYC = `CSS_SS4_CYC
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              run_i,
    output css_pkg::css_lim_t      lim_o
);
    import css_pkg::*;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    css_lim_t    lim_ff;
    css_lim_t    nxt_lim;
    // Counter saturates at the last step so it never wraps back to low limit
    assign nxt_cnt = !run_i ? 16'h0000 :
                     (cnt_ff >= 16'(SS4_CYC)) ? cnt_ff : cnt_ff + 16'h0001;
    // Limit follows elapsed switching time
    assign nxt_lim = !run_i                  ? `CSS_LIM_010 :
                     (cnt_ff >= 16'(SS4_CYC)) ? `CSS_LIM_FULL :
                     (cnt_ff >= 16'(SS3_CYC)) ? `CSS_LIM_030 :
                     (cnt_ff >= 16'(SS2_CYC)) ? `CSS_LIM_020 :
                     (cnt_ff >= 16'(SS1_CYC)) ? `CSS_LIM_015 : `CSS_LIM_010;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 16'h0000;
            lim_ff <= `CSS_LIM_010;
        end else begin
            cnt_ff <= nxt_cnt;
            lim_ff <= nxt_lim;
        end
    end
    assign lim_o = lim_ff;
    a_ss_full_limit: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (run_i && cnt_ff >= 16'(SS4_CYC)) |=> (lim_o == `CSS_LIM_FULL))
        else $error("limit not full after last step");
    a_ss_restart_low: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !run_i |=> (lim_o == `CSS_LIM_010))
        else $error("limit not low while stopped");
endmodule

// *** core/css_sequencer.sv ***
// Startup, undervoltage and overload sequencer for a flyback controller
`timescale 1ns/10ps
`include "css_map.svh"
module css_sequencer #(
    parameter int OLP_CYC = `CSS_OLP_CYC,
    parameter int SS1_CYC = `CSS_SS1_CYC,
    parameter int SS2_CYC = `CSS_SS2_CYC,
    parameter int SS3_CYC = `CSS_SS3_CYC,
    parameter int SS4_CYC = `CSS_SS4_CYC
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic         supply_above_short_i,
    input  wire logic         supply_above_release_i,
    input  wire logic         supply_below_trip_i,
    input  wire logic         protect_normal_i,
    input  wire logic         fb_above_olp_rise_i,
    input  wire logic         fb_below_olp_fall_i,
    input  wire logic         fb_light_load_i,
    output logic              start_enable_o,
    output logic              start_short_limit_o,
    output css_pkg::css_lim_t limit_code_o,
    output logic              switch_enable_o,
    output logic              burst_mode_o,
    output logic              overload_stop_o
);
    import css_pkg::*;

    css_sync_if sif ();
    logic [6:0] raw_in;
    logic [6:0] syn;

    // Comparator flags are asynchronous to the core clock
    assign raw_in = {fb_light_load_i, fb_below_olp_fall_i,
                     fb_above_olp_rise_i, protect_normal_i,
                     supply_below_trip_i, supply_above_release_i,
                     supply_above_short_i};

    css_sync #(
        .N (7)
    ) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (raw_in),
        .sync_o  (syn)
    );

    assign sif.short_ok   = syn[0];
    assign sif.uv_release = syn[1];
    assign sif.uv_trip    = syn[2];
    assign sif.prot_ok    = syn[3];
    assign sif.olp_rise   = syn[4];
    assign sif.olp_fall   = syn[5];
    assign sif.light_load = syn[6];

    css_state_t  state_ff;
    css_state_t  nxt_state;
    logic        olp_ff;
    logic        nxt_olp;
    logic [19:0] olp_cnt_ff;
    logic [19:0] nxt_olp_cnt;
    logic        olp_done;
    logic        running;
    logic        olp_hit_ff;
    logic        nxt_olp_hit;

    // Hysteretic overload flag: set on rise level, cleared on fall level
    assign nxt_olp = sif.olp_rise ? 1'b1 :
                     sif.olp_fall ? 1'b0 : olp_ff;

    assign running  = (state_ff == CSS_ST_RUN);
    assign olp_done = (olp_cnt_ff >= 20'(OLP_CYC - 1));

    // Timer counts only uninterrupted overload while switching
    assign nxt_olp_cnt = (!running || !olp_ff) ? 20'h00000 :
                         olp_done ? olp_cnt_ff :
                         olp_cnt_ff + 20'h00001;

    // Sticky marker of an overload stop, dropped on a clean restart
    assign nxt_olp_hit = (running && olp_ff && olp_done) ? 1'b1 :
                         (nxt_state == CSS_ST_RUN) ? 1'b0 : olp_hit_ff;

    // Sequencer next-state decode
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            CSS_ST_SHORT: begin
                if (sif.short_ok) begin
                    nxt_state = CSS_ST_CHARGE;
                end
            end
            CSS_ST_CHARGE: begin
                if (!sif.short_ok) begin
                    nxt_state = CSS_ST_SHORT;
                end else if (sif.uv_release && sif.prot_ok) begin
                    nxt_state = CSS_ST_RUN;
                end else if (sif.uv_release) begin
                    nxt_state = CSS_ST_OLP_WAIT;
                end
            end
            CSS_ST_RUN: begin
                if (sif.uv_trip) begin
                    nxt_state = CSS_ST_RECHARGE;
                end else if (olp_ff && olp_done) begin
                    nxt_state = CSS_ST_OLP_WAIT;
                end else if (!sif.prot_ok) begin
                    nxt_state = CSS_ST_OLP_WAIT;
                end
            end
            CSS_ST_OLP_WAIT: begin
                // Charging off; waits for trip, or for protections to settle when no overload stop is marked
                if (sif.uv_trip) begin
                    nxt_state = CSS_ST_RECHARGE;
                end else if (sif.prot_ok && !olp_hit_ff) begin
                    nxt_state = CSS_ST_RUN;
                end
            end
            CSS_ST_RECHARGE: begin
                if (!sif.short_ok) begin
                    nxt_state = CSS_ST_SHORT;
                end else if (sif.uv_release && !sif.uv_trip) begin
                    nxt_state = sif.prot_ok ? CSS_ST_RUN
                                            : CSS_ST_OLP_WAIT;
                end
            end
        endcase
    end

    // State, overload flag and timer
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff   <= CSS_ST_SHORT;
            olp_ff     <= 1'b0;
            olp_cnt_ff <= 20'h00000;
            olp_hit_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            olp_ff     <= nxt_olp;
            olp_cnt_ff <= nxt_olp_cnt;
            olp_hit_ff <= nxt_olp_hit;
        end
    end

    // Soft-start limit restarts low on every run entry
    css_softstart #(
        .SS1_CYC (SS1_CYC),
        .SS2_CYC (SS2_CYC),
        .SS3_CYC (SS3_CYC),
        .SS4_CYC (SS4_CYC)
    ) u_ss (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .run_i   (running),
        .lim_o   (limit_code_o)
    );

    logic start_en_ff, short_lim_ff, sw_en_ff, burst_ff;
    logic nxt_start_en, nxt_short_lim, nxt_sw_en, nxt_burst;

    // Start circuit on only in the charging states
    assign nxt_start_en  = (nxt_state == CSS_ST_SHORT) ||
                           (nxt_state == CSS_ST_CHARGE) ||
                           (nxt_state == CSS_ST_RECHARGE);
    assign nxt_short_lim = (nxt_state == CSS_ST_SHORT);
    // Trip gates switching combinationally-early via next state
    assign nxt_sw_en     = (nxt_state == CSS_ST_RUN);
    // Burst is advisory to the PWM core, only meaningful while switching
    assign nxt_burst     = (nxt_state == CSS_ST_RUN) && sif.light_load;

    // Output flops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_en_ff  <= 1'b1;
            short_lim_ff <= 1'b1;
            sw_en_ff     <= 1'b0;
            burst_ff     <= 1'b0;
        end else begin
            start_en_ff  <= nxt_start_en;
            short_lim_ff <= nxt_short_lim;
            sw_en_ff     <= nxt_sw_en;
            burst_ff     <= nxt_burst;
        end
    end

    assign start_enable_o      = start_en_ff;
    assign start_short_limit_o = short_lim_ff;
    assign switch_enable_o     = sw_en_ff;
    assign burst_mode_o        = burst_ff;
    assign overload_stop_o     = olp_hit_ff;

    // Helper count of overload cycles while switching; kept apart from
    // the timer so the timeout checks do not trust what they guard
    logic [19:0] chk_olp_ff;
    logic [19:0] nxt_chk_olp;
    assign nxt_chk_olp = !(running && olp_ff) ? 20'h00000 :
                         (chk_olp_ff == 20'hfffff) ? chk_olp_ff :
                         chk_olp_ff + 20'h00001;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chk_olp_ff <= 20'h00000;
        end else begin
            chk_olp_ff <= nxt_chk_olp;
        end
    end

    // Supply thresholds and the start circuit
    a_trip_stops_sw: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        sif.uv_trip |=> !switch_enable_o)
        else $error("switching kept on below trip");
    a_release_no_chg: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_ff == CSS_ST_RUN) |-> !start_enable_o)
        else $error("charging while running");
    a_sw_no_charge: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        switch_enable_o |-> !start_enable_o)
        else $error("charging while switching");
    a_short_mode: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_ff == CSS_ST_SHORT) |-> start_short_limit_o && start_enable_o)
        else $error("short mode not limited");
    a_short_needs_chg: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        start_short_limit_o |-> start_enable_o)
        else $error("short limit without charging");
    a_full_charge: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_ff == CSS_ST_CHARGE) |-> !start_short_limit_o && start_enable_o)
        else $error("charge not full current");

    // Protections gate switching; soft start restarts low
    a_run_needs_ok: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(switch_enable_o) |-> $past(sif.prot_ok))
        else $error("switching without normal protections");
    a_prot_loss: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (running && !sif.prot_ok) |=> !switch_enable_o)
        else $error("switching kept after protection loss");
    a_ss_entry_low: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(running) |-> (limit_code_o == `CSS_LIM_010))
        else $error("limit not low on run entry");

    // Overload flag hysteresis and timer
    a_olp_set_rise: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        sif.olp_rise |=> olp_ff)
        else $error("overload flag not set on rise");
    a_olp_hold: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (!sif.olp_rise && !sif.olp_fall) |=> (olp_ff == $past(olp_ff)))
        else $error("overload flag moved between levels");
    a_olp_drop_fall: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (sif.olp_fall && !sif.olp_rise) |=> !olp_ff)
        else $error("overload flag not cleared on fall");
    a_olp_clear: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (!olp_ff) |-> (olp_cnt_ff == 20'h00000) || $past(olp_ff))
        else $error("overload timer not cleared");
    a_olp_cnt_step: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (running && olp_ff && !olp_done) |=>
        (olp_cnt_ff == $past(olp_cnt_ff) + 20'h00001))
        else $error("overload timer did not step");
    a_olp_timeout: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (running && olp_ff && olp_done && !sif.uv_trip) |=> !running)
        else $error("overload timeout ignored");
    a_olp_max_run: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (chk_olp_ff >= 20'(OLP_CYC)) |-> !running)
        else $error("switching past overload timeout");
    a_olp_not_early: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ($fell(running) && $past(olp_ff) && $past(sif.prot_ok)
         && !$past(sif.uv_trip))
        |-> ($past(chk_olp_ff) == 20'(OLP_CYC - 1)))
        else $error("overload stop before timeout");
    a_stop_marked: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (running && olp_ff && olp_done) |=> overload_stop_o)
        else $error("overload stop not marked");

    // Auto recovery and burst
    a_olp_recharge: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_ff == CSS_ST_OLP_WAIT && sif.uv_trip) |=> start_enable_o)
        else $error("no recharge after overload");
    a_wait_holds: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_ff == CSS_ST_OLP_WAIT && olp_hit_ff && !sif.uv_trip)
        |=> !running)
        else $error("retry without recharge");
    a_retry_start: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_ff == CSS_ST_RECHARGE && sif.short_ok && sif.uv_release
         && !sif.uv_trip) |=> !start_enable_o)
        else $error("charging kept after recharge");
    a_burst_run: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        burst_mode_o |-> switch_enable_o)
        else $error("burst outside switching");
endmodule

// *** sim/css_front_model.sv ***
// Comparator front end model turning supply and feedback levels into flags
`timescale 1ns/10ps
module css_front_model (
    input  wire logic [9:0] vcc_dv_i,
    input  wire logic [9:0] fb_cv_i,
    input  wire logic       prot_ok_i,
    output logic            above_short_o,
    output logic            above_release_o,
    output logic            below_trip_o,
    output logic            prot_o,
    output logic            olp_rise_o,
    output logic            olp_fall_o,
    output logic            light_o
);
    // Supply comparators, levels in tenths of a volt
    assign above_short_o   = vcc_dv_i > 10'h008;
    assign above_release_o = vcc_dv_i > 10'h087;
    assign below_trip_o    = vcc_dv_i < 10'h052;
    assign prot_o          = prot_ok_i;
    // Feedback comparators in hundredths; fall sits 0.2 V under rise
    assign olp_rise_o = fb_cv_i > 10'h118;
    assign olp_fall_o = fb_cv_i < 10'h104;
    assign light_o    = fb_cv_i < 10'h028;
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the startup protection sequencer
`timescale 1ns/10ps
module testbench;
    import css_pkg::*;
    logic       clock_i;
    logic       rst_n_i;
    logic [9:0] vcc_dv;
    logic [9:0] fb_cv;
    logic       prot_ok;
    logic       a_sh, a_rl, b_tr, p_ok, o_ri, o_fa, l_ld;
    logic       st_en, st_sh, sw_en, burst, olp_stop;
    css_lim_t   lim;
    int         err_count;
    int         n_compared;
    int         offs[5] = '{2, 4, 6, 12, 16};

    css_front_model FE (.vcc_dv_i(vcc_dv), .fb_cv_i(fb_cv),
        .prot_ok_i(prot_ok), .above_short_o(a_sh), .above_release_o(a_rl),
        .below_trip_o(b_tr), .prot_o(p_ok), .olp_rise_o(o_ri),
        .olp_fall_o(o_fa), .light_o(l_ld));

    // Short counts keep the run brief
    css_sequencer #(.OLP_CYC(40), .SS1_CYC(4), .SS2_CYC(8), .SS3_CYC(16),
        .SS4_CYC(32)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .supply_above_short_i(a_sh), .supply_above_release_i(a_rl),
        .supply_below_trip_i(b_tr), .protect_normal_i(p_ok),
        .fb_above_olp_rise_i(o_ri), .fb_below_olp_fall_i(o_fa),
        .fb_light_load_i(l_ld), .start_enable_o(st_en),
        .start_short_limit_o(st_sh), .limit_code_o(lim),
        .switch_enable_o(sw_en), .burst_mode_o(burst),
        .overload_stop_o(olp_stop));

    // 10 MHz clock
    always #50 clock_i = ~clock_i;

    // Wide enough for the largest output group compared at once
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Levels change just after the rising edge
    task automatic drive(input logic [9:0] v, input logic [9:0] f,
                         input logic p);
        @(posedge clock_i);
        vcc_dv  <= v;
        fb_cv   <= f;
        prot_ok <= p;
    endtask

    // Outputs are looked at on the falling edge, well settled
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // Bounded wait for switching; a hang ends the run
    task automatic wait_run;
        int i;
        for (i = 0; i < 40 && sw_en !== 1'b1; i++) begin
            @(negedge clock_i);
        end
        if (sw_en !== 1'b1) begin
            err_count++;
            finish_test();
        end
    endtask

    task automatic finish_test;
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        rst_n_i = 1'b0;
        vcc_dv = 10'h000;
        fb_cv = 10'h064;
        prot_ok = 1'b0;
        err_count = 0;
        n_compared = 0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        // Supply near a short: reduced charge, then full charge
        drive(10'h005, 10'h064, 1'b0);
        wait_cyc(8);
        check(8'({st_en, st_sh, sw_en}), 8'h06);
        drive(10'h032, 10'h064, 1'b0);
        wait_cyc(8);
        check(8'({st_en, st_sh, sw_en}), 8'h04);
        // Release with a protection abnormal: charging off, no switching
        drive(10'h08c, 10'h064, 1'b0);
        wait_cyc(10);
        check(8'({st_en, sw_en}), 8'h00);
        drive(10'h08c, 10'h064, 1'b1);
        wait_run();
        check(8'({st_en, sw_en}), 8'h01);
        // Current limit steps through the soft-start codes
        for (int k = 0; k < 5; k++) begin
            wait_cyc(offs[k]);
            check(8'(lim), 8'(k));
        end
        // Light load asks for burst operation
        drive(10'h08c, 10'h01e, 1'b1);
        wait_cyc(8);
        check(8'({burst, sw_en}), 8'h03);
        drive(10'h08c, 10'h064, 1'b1);
        wait_cyc(8);
        check(8'(burst), 8'h00);
        // Interrupted overload restarts the timer; hysteresis holds it
        drive(10'h08c, 10'h12c, 1'b1);
        wait_cyc(30);
        drive(10'h08c, 10'h0fa, 1'b1);
        wait_cyc(6);
        drive(10'h08c, 10'h12c, 1'b1);
        wait_cyc(30);
        check(8'({sw_en, olp_stop}), 8'h02);
        drive(10'h08c, 10'h10e, 1'b1);
        wait_cyc(25);
        check(8'({sw_en, olp_stop}), 8'h01);
        // Auto recovery through trip and release
        drive(10'h050, 10'h064, 1'b1);
        wait_cyc(8);
        check(8'({st_en, sw_en}), 8'h02);
        drive(10'h08c, 10'h064, 1'b1);
        wait_run();
        wait_cyc(1);
        check(8'({st_en, olp_stop, lim}), 8'h00);
        // Trip while running stops switching and turns charging back on within 8 cycles
        drive(10'h050, 10'h064, 1'b1);
        wait_cyc(8);
        check(8'({st_en, sw_en}), 8'h02);
        // Reset while recharging after the trip brings every output back to its reset level
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        wait_cyc(2);
        check(8'({st_en, st_sh, sw_en, burst, olp_stop, lim}), 8'hc0);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        wait_cyc(8);
        check(8'({st_en, st_sh, sw_en}), 8'h04);
        finish_test();
    end
endmodule
